// [jtag_tap_boundary_scan.sv]
`timescale 1ns/1ps
// Functional notes
// [R01] Four pins tck, tms, tdi, tdo; standard TAP state machine and register access.
// [R02] Instruction register is 16 bits; seven codes each select a data register.
// [R03] Code 0x0000 selects boundary register controlling and observing all pins.
// [R04] Code 0x0002 selects boundary register for observe and preload.
// [R05] Code 0x0004 selects the identification register.
// [R06] Identification register is 32 bits long.
// [R07] Code 0xFFFF selects the single-stage bypass register.
// [R08] Code 0x0082 selects the flash control register.
// [R09] Code 0x0083 selects the flash data register.
// [R10] Code 0x0084 selects the flash address register.
// [R11] Boundary register spans all pins, core bus and weak-pullup control.
// [R12] Extest captures and updates; sample captures and preloads, pins not driven by cells.
// [R13] While extest is active all inputs to core logic read as 1.
// [R14] Bits 0..3 serve the reset pin: enables on even, data on odd.
// [R15] Bits 4..7 serve the two bus pins: enables on even, data on odd.
// [R16] Bit 8 captures the crystal input; its update does nothing.
// [R17] Bit 9 captures core weak-pullup enable; update drives it to all ports.
// [R18] From bit 10 each port pin uses an even enable / odd data pair.
// [R19] Any unlisted instruction code selects the bypass register.
// [R20] Flash commands: op code in bits 19:18 (0x poll, 10 read, 11 write).
// [R21] Flash reply: busy in bit 0, read data above; commands ignored while busy.
module jtag_tap_boundary_scan #(
    parameter int NUM_PORT_PINS = jtag_tap_pkg::NUM_PORT_PINS,
    parameter logic [31:0] ID_VALUE = 32'h0000_0001 // Arbitrary value, bit 0 set as required
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    input wire jtag_tap_pkg::pad_t pad_in,
    output jtag_tap_pkg::pad_t pad_out,
    output jtag_tap_pkg::pad_t pad_oe,
    input wire logic crystal_input_pin,
    input wire jtag_tap_pkg::pad_t core_out,
    input wire jtag_tap_pkg::pad_t core_oe,
    output jtag_tap_pkg::pad_t core_in,
    input wire logic core_wpu,
    output logic wpu_to_pins,
    output logic nvm_req,
    output jtag_tap_pkg::nvm_cmd_t nvm_cmd,
    input wire logic nvm_done,
    input wire logic [jtag_tap_pkg::NVM_DATA_W-1:0] nvm_rdata
);
    localparam int BSL = jtag_tap_pkg::BS_PORT_BASE + 2 * NUM_PORT_PINS;
    localparam int DW = jtag_tap_pkg::NVM_DATA_W;

    generate
        if (NUM_PORT_PINS != jtag_tap_pkg::NUM_PORT_PINS)
        begin : g_bad_width
            $error("port pin count must match the pad bundle");
        end
    endgenerate

    function automatic jtag_tap_pkg::tap_state_t tap_next(jtag_tap_pkg::tap_state_t s, logic m);
        case (s)
            jtag_tap_pkg::ST_TLR: tap_next = m ? jtag_tap_pkg::ST_TLR : jtag_tap_pkg::ST_RTI;
            jtag_tap_pkg::ST_RTI: tap_next = m ? jtag_tap_pkg::ST_SEL_DR : jtag_tap_pkg::ST_RTI;
            jtag_tap_pkg::ST_SEL_DR: tap_next = m ? jtag_tap_pkg::ST_SEL_IR : jtag_tap_pkg::ST_CAP_DR;
            jtag_tap_pkg::ST_CAP_DR: tap_next = m ? jtag_tap_pkg::ST_EX1_DR : jtag_tap_pkg::ST_SH_DR;
            jtag_tap_pkg::ST_SH_DR: tap_next = m ? jtag_tap_pkg::ST_EX1_DR : jtag_tap_pkg::ST_SH_DR;
            jtag_tap_pkg::ST_EX1_DR: tap_next = m ? jtag_tap_pkg::ST_UPD_DR : jtag_tap_pkg::ST_PAU_DR;
            jtag_tap_pkg::ST_PAU_DR: tap_next = m ? jtag_tap_pkg::ST_EX2_DR : jtag_tap_pkg::ST_PAU_DR;
            jtag_tap_pkg::ST_EX2_DR: tap_next = m ? jtag_tap_pkg::ST_UPD_DR : jtag_tap_pkg::ST_SH_DR;
            jtag_tap_pkg::ST_UPD_DR: tap_next = m ? jtag_tap_pkg::ST_SEL_DR : jtag_tap_pkg::ST_RTI;
            jtag_tap_pkg::ST_SEL_IR: tap_next = m ? jtag_tap_pkg::ST_TLR : jtag_tap_pkg::ST_CAP_IR;
            jtag_tap_pkg::ST_CAP_IR: tap_next = m ? jtag_tap_pkg::ST_EX1_IR : jtag_tap_pkg::ST_SH_IR;
            jtag_tap_pkg::ST_SH_IR: tap_next = m ? jtag_tap_pkg::ST_EX1_IR : jtag_tap_pkg::ST_SH_IR;
            jtag_tap_pkg::ST_EX1_IR: tap_next = m ? jtag_tap_pkg::ST_UPD_IR : jtag_tap_pkg::ST_PAU_IR;
            jtag_tap_pkg::ST_PAU_IR: tap_next = m ? jtag_tap_pkg::ST_EX2_IR : jtag_tap_pkg::ST_PAU_IR;
            jtag_tap_pkg::ST_EX2_IR: tap_next = m ? jtag_tap_pkg::ST_UPD_IR : jtag_tap_pkg::ST_SH_IR;
            jtag_tap_pkg::ST_UPD_IR: tap_next = m ? jtag_tap_pkg::ST_SEL_DR : jtag_tap_pkg::ST_RTI;
            default: tap_next = jtag_tap_pkg::ST_TLR;
        endcase
    endfunction

    function automatic jtag_tap_pkg::dr_sel_t dr_select(logic [15:0] code);
        case (code)
            jtag_tap_pkg::IR_EXTEST, jtag_tap_pkg::IR_SAMPLE: dr_select = jtag_tap_pkg::SEL_BOUNDARY; // [R03] [R04]
            jtag_tap_pkg::IR_IDCODE: dr_select = jtag_tap_pkg::SEL_IDENT; // [R05]
            jtag_tap_pkg::IR_NVM_CTRL, jtag_tap_pkg::IR_NVM_DATA,
            jtag_tap_pkg::IR_NVM_ADDR: dr_select = jtag_tap_pkg::SEL_NVM; // [R08] [R09] [R10]
            default: dr_select = jtag_tap_pkg::SEL_BYPASS; // [R07] [R19]
        endcase
    endfunction

    // Reset release into the link domain; assertion stays asynchronous
    logic tck_rst_s1;
    logic tck_rst;
    always_ff @(posedge tck or posedge rst)
    begin
        if (rst)
        begin
            tck_rst_s1 <= 1'b1;
            tck_rst <= 1'b1;
        end
        else
        begin
            tck_rst_s1 <= 1'b0;
            tck_rst <= tck_rst_s1;
        end
    end

    jtag_tap_pkg::tap_state_t tap_reg;
    always_ff @(posedge tck or posedge tck_rst)
    begin
        if (tck_rst)
            tap_reg <= jtag_tap_pkg::ST_TLR;
        else
            tap_reg <= tap_next(tap_reg, tms); // [R01]
    end

    logic [jtag_tap_pkg::IR_LEN-1:0] instr_shift_reg;
    logic [jtag_tap_pkg::IR_LEN-1:0] test_instruction_reg;
    always_ff @(posedge tck or posedge tck_rst)
    begin
        if (tck_rst)
        begin
            instr_shift_reg <= jtag_tap_pkg::IR_CAPTURE;
            test_instruction_reg <= jtag_tap_pkg::IR_RESET;
        end
        else
        begin
            case (tap_reg)
                jtag_tap_pkg::ST_TLR: test_instruction_reg <= jtag_tap_pkg::IR_RESET;
                jtag_tap_pkg::ST_CAP_IR: instr_shift_reg <= jtag_tap_pkg::IR_CAPTURE;
                jtag_tap_pkg::ST_SH_IR: instr_shift_reg <= {tdi, instr_shift_reg[jtag_tap_pkg::IR_LEN-1:1]}; // [R02]
                jtag_tap_pkg::ST_UPD_IR: test_instruction_reg <= instr_shift_reg; // [R02]
                default: test_instruction_reg <= test_instruction_reg;
            endcase
        end
    end

    jtag_tap_pkg::dr_sel_t sel;
    logic extest;
    jtag_tap_pkg::nvm_target_t target;
    assign sel = dr_select(test_instruction_reg);
    assign extest = (test_instruction_reg == jtag_tap_pkg::IR_EXTEST);
    assign target = (test_instruction_reg == jtag_tap_pkg::IR_NVM_CTRL) ? jtag_tap_pkg::NVM_CTRL :
                    (test_instruction_reg == jtag_tap_pkg::IR_NVM_DATA) ? jtag_tap_pkg::NVM_DATA :
                    jtag_tap_pkg::NVM_ADDR;

    // Capture sources: pins and core levels are foreign to tck, so each bit is synchronised
    logic [BSL-1:0] bs_src;
    logic [BSL-1:0] bs_src_s1;
    logic [BSL-1:0] bs_src_s2;
    assign bs_src[jtag_tap_pkg::BS_RST_OE0] = core_oe.reset_pin; // [R14]
    assign bs_src[jtag_tap_pkg::BS_RST_IO0] = pad_in.reset_pin;
    assign bs_src[jtag_tap_pkg::BS_RST_OE1] = core_oe.reset_pin;
    assign bs_src[jtag_tap_pkg::BS_RST_IO1] = pad_in.reset_pin;
    assign bs_src[jtag_tap_pkg::BS_RX_OE] = core_oe.bus_receive_pin; // [R15]
    assign bs_src[jtag_tap_pkg::BS_RX_IO] = pad_in.bus_receive_pin;
    assign bs_src[jtag_tap_pkg::BS_TX_OE] = core_oe.bus_transmit_pin;
    assign bs_src[jtag_tap_pkg::BS_TX_IO] = pad_in.bus_transmit_pin;
    assign bs_src[jtag_tap_pkg::BS_XTAL] = crystal_input_pin; // [R16]
    assign bs_src[jtag_tap_pkg::BS_WPU] = core_wpu; // [R17]

    logic [BSL-1:0] bs_shift_reg;
    logic [BSL-1:0] bs_upd_reg;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PORT_PINS; gi++)
        begin : g_port
            assign bs_src[jtag_tap_pkg::BS_PORT_BASE + 2 * gi] = core_oe.port[gi]; // [R18]
            assign bs_src[jtag_tap_pkg::BS_PORT_BASE + 2 * gi + 1] = pad_in.port[gi];
            assign pad_oe.port[gi] = extest ? bs_upd_reg[jtag_tap_pkg::BS_PORT_BASE + 2 * gi] : core_oe.port[gi];
            assign pad_out.port[gi] = extest ? bs_upd_reg[jtag_tap_pkg::BS_PORT_BASE + 2 * gi + 1] : core_out.port[gi];
        end
    endgenerate

    always_ff @(posedge tck or posedge tck_rst)
    begin
        if (tck_rst)
        begin
            bs_src_s1 <= '0;
            bs_src_s2 <= '0;
        end
        else
        begin
            bs_src_s1 <= bs_src;
            bs_src_s2 <= bs_src_s1;
        end
    end

    // Boundary chain: capture under both, update cells only steer pins under extest
    always_ff @(posedge tck or posedge tck_rst)
    begin
        if (tck_rst)
        begin
            bs_shift_reg <= '0;
            bs_upd_reg <= '0;
        end
        else if (sel == jtag_tap_pkg::SEL_BOUNDARY)
        begin
            if (tap_reg == jtag_tap_pkg::ST_CAP_DR)
                bs_shift_reg <= bs_src_s2; // [R11] [R12]
            else if (tap_reg == jtag_tap_pkg::ST_SH_DR)
                bs_shift_reg <= {tdi, bs_shift_reg[BSL-1:1]};
            else if (tap_reg == jtag_tap_pkg::ST_UPD_DR)
                bs_upd_reg <= bs_shift_reg; // [R04] [R12]
        end
    end

    // Redundant reset cell pairs: either enable drives, either low data pulls low
    assign pad_oe.reset_pin = extest ? (bs_upd_reg[jtag_tap_pkg::BS_RST_OE0] | bs_upd_reg[jtag_tap_pkg::BS_RST_OE1])
                                     : core_oe.reset_pin; // [R14]
    assign pad_out.reset_pin = extest ? (bs_upd_reg[jtag_tap_pkg::BS_RST_IO0] & bs_upd_reg[jtag_tap_pkg::BS_RST_IO1])
                                      : core_out.reset_pin; // [R14]
    assign pad_oe.bus_receive_pin = extest ? bs_upd_reg[jtag_tap_pkg::BS_RX_OE] : core_oe.bus_receive_pin; // [R15]
    assign pad_out.bus_receive_pin = extest ? bs_upd_reg[jtag_tap_pkg::BS_RX_IO] : core_out.bus_receive_pin;
    assign pad_oe.bus_transmit_pin = extest ? bs_upd_reg[jtag_tap_pkg::BS_TX_OE] : core_oe.bus_transmit_pin;
    assign pad_out.bus_transmit_pin = extest ? bs_upd_reg[jtag_tap_pkg::BS_TX_IO] : core_out.bus_transmit_pin;
    assign wpu_to_pins = extest ? bs_upd_reg[jtag_tap_pkg::BS_WPU] : core_wpu; // [R17]

    logic byp_reg;
    logic [jtag_tap_pkg::ID_LEN-1:0] id_shift_reg;
    logic [jtag_tap_pkg::NVM_LEN-1:0] nvm_shift_reg;
    logic req_tog_reg;
    logic ack_s1;
    logic ack_s2;
    logic ack_tog_reg;
    logic busy;
    logic [DW-1:0] rdata_m_reg;
    jtag_tap_pkg::nvm_cmd_t cmd_tck_reg;
    assign busy = req_tog_reg ^ ack_s2;

    always_ff @(posedge tck or posedge tck_rst)
    begin
        if (tck_rst)
        begin
            byp_reg <= 1'b0;
            id_shift_reg <= '0;
            nvm_shift_reg <= '0;
        end
        else if (tap_reg == jtag_tap_pkg::ST_CAP_DR)
        begin
            byp_reg <= 1'b0; // [R07]
            id_shift_reg <= ID_VALUE; // [R05] [R06]
            nvm_shift_reg <= {1'b0, rdata_m_reg, busy}; // [R21]
        end
        else if (tap_reg == jtag_tap_pkg::ST_SH_DR)
        begin
            byp_reg <= tdi;
            id_shift_reg <= {tdi, id_shift_reg[jtag_tap_pkg::ID_LEN-1:1]};
            nvm_shift_reg <= {tdi, nvm_shift_reg[jtag_tap_pkg::NVM_LEN-1:1]}; // [R20]
        end
    end

    // Poll (op 0x) has no update effect; read/write launch only while idle
    always_ff @(posedge tck or posedge tck_rst)
    begin
        if (tck_rst)
        begin
            req_tog_reg <= 1'b0;
            cmd_tck_reg <= '0;
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
        end
        else
        begin
            ack_s1 <= ack_tog_reg;
            ack_s2 <= ack_s1;
            if (tap_reg == jtag_tap_pkg::ST_UPD_DR && sel == jtag_tap_pkg::SEL_NVM
                && nvm_shift_reg[jtag_tap_pkg::NVM_OP_HI] && !busy)
            begin
                req_tog_reg <= ~req_tog_reg; // [R20] [R21]
                cmd_tck_reg <= {nvm_shift_reg[jtag_tap_pkg::NVM_OP_LO], target, nvm_shift_reg[DW-1:0]};
            end
        end
    end

    logic tdo_reg;
    logic tdo_oe_reg;
    always_ff @(negedge tck or posedge tck_rst)
    begin
        if (tck_rst)
        begin
            tdo_reg <= 1'b0;
            tdo_oe_reg <= 1'b0;
        end
        else
        begin
            tdo_oe_reg <= (tap_reg == jtag_tap_pkg::ST_SH_DR) || (tap_reg == jtag_tap_pkg::ST_SH_IR); // [R01]
            if (tap_reg == jtag_tap_pkg::ST_SH_IR)
                tdo_reg <= instr_shift_reg[0];
            else
                case (sel)
                    jtag_tap_pkg::SEL_BOUNDARY: tdo_reg <= bs_shift_reg[0];
                    jtag_tap_pkg::SEL_IDENT: tdo_reg <= id_shift_reg[0];
                    jtag_tap_pkg::SEL_NVM: tdo_reg <= nvm_shift_reg[0];
                    default: tdo_reg <= byp_reg;
                endcase
        end
    end
    assign tdo = tdo_reg;
    assign tdo_oe = tdo_oe_reg;

    // System clock side: request toggle in, acknowledge toggle out
    logic req_s1;
    logic req_s2;
    logic req_s3;
    logic pend_reg;
    logic nvm_req_reg;
    jtag_tap_pkg::nvm_cmd_t nvm_cmd_reg;
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            req_s3 <= 1'b0;
            pend_reg <= 1'b0;
            ack_tog_reg <= 1'b0;
            nvm_req_reg <= 1'b0;
            nvm_cmd_reg <= '0;
            rdata_m_reg <= '0;
        end
        else
        begin
            req_s1 <= req_tog_reg;
            req_s2 <= req_s1;
            req_s3 <= req_s2;
            nvm_req_reg <= req_s2 ^ req_s3;
            if (req_s2 ^ req_s3)
            begin
                pend_reg <= 1'b1;
                nvm_cmd_reg <= cmd_tck_reg;
            end
            else if (nvm_done && pend_reg)
            begin
                pend_reg <= 1'b0;
                ack_tog_reg <= ~ack_tog_reg; // [R21]
                rdata_m_reg <= nvm_rdata;
            end
        end
    end
    assign nvm_req = nvm_req_reg;
    assign nvm_cmd = nvm_cmd_reg;

    // Core sees pins through three flops; all ones while extest holds the pins
    logic ext_s1;
    logic ext_s2;
    jtag_tap_pkg::pad_t pin_s1;
    jtag_tap_pkg::pad_t pin_s2;
    jtag_tap_pkg::pad_t core_in_reg;
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            // Reset instruction is extest, so core inputs stay forced through release
            ext_s1 <= 1'b1;
            ext_s2 <= 1'b1;
            pin_s1 <= '0;
            pin_s2 <= '0;
            core_in_reg <= '1;
        end
        else
        begin
            ext_s1 <= extest;
            ext_s2 <= ext_s1;
            pin_s1 <= pad_in;
            pin_s2 <= pin_s1;
            core_in_reg <= ext_s2 ? '1 : pin_s2; // [R13]
        end
    end
    assign core_in = core_in_reg;

    sequence tms_five;
        tms [*5];
    endsequence
    // Capture edge that leads straight into shift, so bit 0 shows on the next fall
    sequence ident_enter;
        tap_reg == jtag_tap_pkg::ST_CAP_DR && sel == jtag_tap_pkg::SEL_IDENT && !tms;
    endsequence
    chk_tap_reset_walk: assert property (@(posedge tck) disable iff (tck_rst) // [R01]
        tms_five |=> tap_reg == jtag_tap_pkg::ST_TLR) else $error("tap not reset by tms");
    chk_instr_reset_value: assert property (@(posedge tck) disable iff (tck_rst) // [R02]
        tap_reg == jtag_tap_pkg::ST_TLR |=> test_instruction_reg == jtag_tap_pkg::IR_RESET)
        else $error("instruction not reset");
    chk_ident_capture: assert property (@(posedge tck) disable iff (tck_rst) // [R05] [R06]
        ident_enter |=> tdo == ID_VALUE[0]) else $error("identity bit 0 wrong");
    chk_unknown_bypass: assert property (@(posedge tck) disable iff (tck_rst) // [R19]
        test_instruction_reg == 16'h0001 |-> sel == jtag_tap_pkg::SEL_BYPASS)
        else $error("unknown code not bypass");
    chk_extest_drive: assert property (@(posedge tck) disable iff (tck_rst) // [R12]
        extest |-> pad_oe.port[0] == bs_upd_reg[jtag_tap_pkg::BS_PORT_BASE]) else $error("extest not driving");
    chk_sample_nodrive: assert property (@(posedge tck) disable iff (tck_rst) // [R12]
        !extest |-> pad_oe == core_oe && pad_out == core_out) else $error("scan cells drive pins");
    chk_busy_ignore: assert property (@(posedge tck) disable iff (tck_rst) // [R21]
        busy |=> $stable(req_tog_reg)) else $error("command taken while busy");
    chk_poll_noop: assert property (@(posedge tck) disable iff (tck_rst) // [R20]
        tap_reg == jtag_tap_pkg::ST_UPD_DR && !nvm_shift_reg[jtag_tap_pkg::NVM_OP_HI] |=> $stable(req_tog_reg))
        else $error("poll launched op");
    chk_core_forced: assert property (@(posedge mclk) disable iff (rst) // [R13]
        ext_s2 |=> core_in == '1) else $error("core input not forced");
endmodule

// [jtag_tap_pkg.sv]
package jtag_tap_pkg;
    localparam int IR_LEN = 16;
    localparam logic [15:0] IR_EXTEST = 16'h0000;
    localparam logic [15:0] IR_SAMPLE = 16'h0002;
    localparam logic [15:0] IR_IDCODE = 16'h0004;
    localparam logic [15:0] IR_BYPASS = 16'hFFFF;
    localparam logic [15:0] IR_NVM_CTRL = 16'h0082;
    localparam logic [15:0] IR_NVM_DATA = 16'h0083;
    localparam logic [15:0] IR_NVM_ADDR = 16'h0084;
    localparam logic [15:0] IR_RESET = 16'h0000;
    localparam logic [15:0] IR_CAPTURE = 16'h0001;
    localparam int ID_LEN = 32;
    localparam int NVM_LEN = 20;
    localparam int NVM_DATA_W = 18;
    localparam int NVM_OP_HI = 19;
    localparam int NVM_OP_LO = 18;
    localparam int NUM_PORT_PINS = 64;
    localparam int BS_RST_OE0 = 0;
    localparam int BS_RST_IO0 = 1;
    localparam int BS_RST_OE1 = 2;
    localparam int BS_RST_IO1 = 3;
    localparam int BS_RX_OE = 4;
    localparam int BS_RX_IO = 5;
    localparam int BS_TX_OE = 6;
    localparam int BS_TX_IO = 7;
    localparam int BS_XTAL = 8;
    localparam int BS_WPU = 9;
    localparam int BS_PORT_BASE = 10;
    localparam int BS_LEN = BS_PORT_BASE + 2 * NUM_PORT_PINS;

    typedef enum logic [15:0] {
        ST_TLR = 16'h0001, ST_RTI = 16'h0002, ST_SEL_DR = 16'h0004, ST_CAP_DR = 16'h0008,
        ST_SH_DR = 16'h0010, ST_EX1_DR = 16'h0020, ST_PAU_DR = 16'h0040, ST_EX2_DR = 16'h0080,
        ST_UPD_DR = 16'h0100, ST_SEL_IR = 16'h0200, ST_CAP_IR = 16'h0400, ST_SH_IR = 16'h0800,
        ST_EX1_IR = 16'h1000, ST_PAU_IR = 16'h2000, ST_EX2_IR = 16'h4000, ST_UPD_IR = 16'h8000
    } tap_state_t;

    typedef enum logic [3:0] {
        SEL_BYPASS = 4'h1, SEL_BOUNDARY = 4'h2, SEL_IDENT = 4'h4, SEL_NVM = 4'h8
    } dr_sel_t;

    typedef enum logic [1:0] {
        NVM_CTRL = 2'h0, NVM_DATA = 2'h1, NVM_ADDR = 2'h2
    } nvm_target_t;

    typedef struct packed {
        logic [NUM_PORT_PINS-1:0] port;
        logic bus_transmit_pin;
        logic bus_receive_pin;
        logic reset_pin;
    } pad_t;

    typedef struct packed {
        logic we;
        nvm_target_t target;
        logic [NVM_DATA_W-1:0] wdata;
    } nvm_cmd_t;
endpackage

// [jtag_host_model.sv]
`timescale 1ns/1ps
module jtag_host_model (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    // Test clock stands still between frames
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // Changes after the falling edge, tdo sampled just before the rise
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #15;
        q = tdo;
        tck = 1'b1;
        #15;
        tck = 1'b0;
    endtask

    task automatic reset_tap();
        logic q;
        repeat (6) step(1'b1, ~tdi, q);
        step(1'b0, ~tdi, q);
    endtask

    task automatic idle(input int n);
        logic q;
        repeat (n) step(1'b0, ~tdi, q);
    endtask

    // Idle to idle, LSB first; data line toggles once released
    task automatic scan(input logic ir, input int n, input logic [137:0] din, output logic [137:0] dout);
        logic q;
        dout = '0;
        step(1'b1, ~tdi, q);
        if (ir)
            step(1'b1, ~tdi, q);
        step(1'b0, ~tdi, q);
        step(1'b0, ~tdi, q);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, ~tdi, q);
        step(1'b0, ~tdi, q);
    endtask
endmodule

// [jtag_tap_boundary_scan_bench.sv]
`timescale 1ns/1ps
module jtag_tap_boundary_scan_bench;
    localparam logic [31:0] ID_TEST = 32'h5A3C_0F01; // Arbitrary value
    logic mclk, rst, tck, tms, tdi, tdo, tdo_oe, crystal_input_pin, core_wpu, wpu_to_pins, nvm_req;
    logic nvm_done = 1'b0;
    jtag_tap_pkg::pad_t pad_in, pad_out, pad_oe, core_out, core_oe, core_in;
    jtag_tap_pkg::nvm_cmd_t nvm_cmd, last_cmd;
    logic [17:0] nvm_rdata;
    logic [137:0] sout, pat;
    logic [15:0] byp[4] = '{16'hFFFF, 16'h1234, 16'h0001, 16'h8000};
    logic [15:0] nvm_ir[3] = '{16'h0082, 16'h0083, 16'h0084};
    int failures = 0, total_checks = 0, req_count = 0, done_delay = 4, rc;

    jtag_tap_boundary_scan #(.ID_VALUE(ID_TEST)) i_jtag_tap_boundary_scan (.mclk, .rst, .tck, .tms, .tdi, .tdo,
        .tdo_oe, .pad_in, .pad_out, .pad_oe, .crystal_input_pin, .core_out, .core_oe, .core_in, .core_wpu,
        .wpu_to_pins, .nvm_req, .nvm_cmd, .nvm_done, .nvm_rdata);
    jtag_host_model i_jtag_host_model (.tck, .tms, .tdi, .tdo);

    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // Core side of the flash path
    always @(posedge mclk)
        if (nvm_req)
        begin
            req_count <= req_count + 1;
            last_cmd <= nvm_cmd;
        end

    always
    begin
        @(posedge mclk iff nvm_req === 1'b1);
        repeat (done_delay) @(negedge mclk);
        nvm_done = 1'b1;
        @(negedge mclk);
        nvm_done = 1'b0;
    end

    task automatic check(input logic [137:0] seen, input logic [137:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        if (failures == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic waitc(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic load_ir(input logic [15:0] code);
        i_jtag_host_model.scan(1'b1, 16, 138'(code), sout);
        check(sout[15:0], 16'h0001);
    endtask

    task automatic dr(input int n, input logic [137:0] d);
        i_jtag_host_model.scan(1'b0, n, d, sout);
    endtask

    function automatic logic [137:0] cap_of();
        logic [137:0] v;
        v[9:0] = {core_wpu, crystal_input_pin, pad_in.bus_transmit_pin, core_oe.bus_transmit_pin,
            pad_in.bus_receive_pin, core_oe.bus_receive_pin, {2{pad_in.reset_pin, core_oe.reset_pin}}};
        for (int j = 0; j < 64; j++)
            v[11 + 2 * j -: 2] = {pad_in.port[j], core_oe.port[j]};
        return v;
    endfunction

    task automatic check_pads(input logic [137:0] p);
        jtag_tap_pkg::pad_t eo, ee;
        for (int j = 0; j < 64; j++)
            {eo.port[j], ee.port[j]} = p[11 + 2 * j -: 2];
        {eo.bus_transmit_pin, ee.bus_transmit_pin, eo.bus_receive_pin, ee.bus_receive_pin} = p[7:4];
        ee.reset_pin = p[0] | p[2];
        eo.reset_pin = p[1] & p[3];
        check(pad_oe, ee);
        check(pad_out, eo);
        check(wpu_to_pins, p[9]);
    endtask

    initial
    begin
        rst = 1'b1;
        pad_in = 67'h2_A5A5_1234_F0F0_3C3C;
        core_out = 67'h1_0F0F_5555_00FF_9669;
        core_oe = 67'h6_33CC_AAAA_0F0F_C3C3;
        crystal_input_pin = 1'b1;
        core_wpu = 1'b0;
        nvm_rdata = 18'h2D6B1;
        fork
            waitc(16);
            i_jtag_host_model.reset_tap();
        join
        rst = 1'b0;
        i_jtag_host_model.reset_tap();
        check(tdo_oe, 1'b0);
        check(pad_oe, 67'h0);
        check(core_in, {67{1'b1}});
        for (int k = 0; k < 2; k++)
        begin
            pat = k ? ~pat : 138'({5{28'hB4E1D27}});
            dr(138, pat);
            check(sout, cap_of());
            waitc(4);
            check_pads(pat);
            check(core_in, {67{1'b1}});
        end
        core_wpu = 1'b1;
        crystal_input_pin = 1'b0;
        pad_in = ~pad_in;
        load_ir(16'h0002);
        dr(138, ~pat);
        check(sout, cap_of());
        waitc(4);
        check(pad_out, core_out);
        check(pad_oe, core_oe);
        check(wpu_to_pins, 1'b1);
        check(core_in, pad_in);
        load_ir(16'h0000);
        waitc(4);
        check_pads(~pat);
        load_ir(16'h0004);
        dr(33, 138'h1);
        check(sout[32:0], {1'b1, ID_TEST});
        foreach (byp[k])
        begin
            load_ir(byp[k]);
            dr(2, 138'h1);
            check(sout[1:0], 2'b10);
        end
        // Long answer so a second command lands while busy
        done_delay = 300;
        load_ir(16'h0083);
        rc = req_count;
        dr(20, {2'b11, 18'h31A2B});
        waitc(8);
        check(req_count, rc + 1);
        check(last_cmd, {1'b1, 2'h1, 18'h31A2B});
        dr(20, {2'b10, 18'h0});
        check(sout[0], 1'b1);
        waitc(8);
        check(req_count, rc + 1);
        done_delay = 4;
        waitc(320);
        foreach (nvm_ir[k])
        begin
            load_ir(nvm_ir[k]);
            i_jtag_host_model.idle(4);
            dr(20, 138'h0);
            check(sout[19:0], {1'b0, nvm_rdata, 1'b0});
            rc = req_count;
            dr(20, {2'b10, 18'h00055});
            waitc(16);
            check(req_count, rc + 1);
            check(last_cmd[20:18], {1'b0, 2'(k)});
        end
        finish_test();
    end

    initial
    begin
        #400_000;
        failures++;
        finish_test();
    end
endmodule
